// File: rtl/frr_cmd.sv
// Operation
// - Resume is one byte 30h framed alone by chip select; resumes suspended write.
// - Accepted resume clears the erase-held and program-held flags.
// - Busy stays set after resume until resumed internal write completes.
// - Resume needs no earlier write-latch-set command.
// - Resume ignored while performance enhance mode is on.
// - No-operation only cancels a pending reset-arm, nothing else.
// - Commands take 8 clocks single-line or 2 clocks four-line.
// - Software reset restores standby and all volatile power-on defaults; here it clears busy, both held flags and the arm, not the mode inputs.
// - Reset-execute acts only right after reset-arm; others cancel arm.
// - Reset during program or erase aborts it; data may be lost.
// - Reset needs recovery time; host waits before new commands.
// - Table read: 5Ah, three address bytes, one dummy, then data out.
// - Raising chip select during data output stops the drive.
// - Byte 06h is header count 02h; byte 07h reads FFh.
// - Header at 08h: id 00h, minor 06h, major 01h.
// - Byte 0Bh gives the standard table length 10h double words.
// - Bytes 0Ch-0Eh give pointer 30h LSB first; 0Fh reads FFh.
`timescale 1ns/1ps
`include "frr_defs.svh"
module frr_cmd (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] sio_in,
  input wire logic four_line_cmd_mode,
  input wire logic perf_enh_mode,
  input wire logic erase_held_set,
  input wire logic program_held_set,
  input wire logic write_done,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe,
  output logic erase_held_flag,
  output logic program_held_flag,
  output logic busy_flag,
  output logic resume_pulse,
  output logic soft_reset_pulse,
  output logic write_abort_pulse,
  output logic recovering,
  output logic reset_arm_cmd
);
  logic cs_n_s;
  logic sclk_s;
  logic [3:0] sio_s;
  logic sclk_d_reg;
  logic rise;
  logic fall;
  logic cs_rise;
  logic cs_d_reg;
  frr_pkg::frr_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] cmd_reg;
  logic [7:0] tbl_addr_reg;
  logic [7:0] out_byte_reg;
  logic [3:0] out_cnt_reg;
  logic [7:0] prod_cnt_reg;
  logic [7:0] tbl_addr;
  logic prod_push;
  logic load;
  logic [7:0] next_byte;
  logic [7:0] shift_src;
  logic cmd_first;
  logic cmd_ok;
  logic resume_go;
  logic rst_go;
  logic [3:0] bits_per_byte;
  logic [7:0] byte_in;
  logic byte_done;
  logic frame_bytes_reg;
  logic [31:0] rec_cnt_reg;
  logic param_table_read_cmd;
  frr_fifo_if ff ();

  // All checks run on the core clock and rest during reset
  default clocking dflt_cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // Pins from the host are asynchronous to core_clk
  frr_sync #(.WIDTH(6)) u_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .d({cs_n, sclk, sio_in}),
    .q({cs_n_s, sclk_s, sio_s})
  );

  // Edge detection on the synchronised serial clock and select
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_n_s;
    end
  end
  assign rise = sclk_s && !sclk_d_reg && !cs_n_s;
  assign fall = !sclk_s && sclk_d_reg && !cs_n_s;
  assign cs_rise = cs_n_s && !cs_d_reg;

  assign bits_per_byte = four_line_cmd_mode ? `FRR_BITS_QUAD : `FRR_BITS_SINGLE;
  // Upper lines ignored in single-line mode
  assign byte_in = four_line_cmd_mode ? {shift_reg[3:0], sio_s} : {shift_reg[6:0], sio_s[0]};
  assign byte_done = rise && (bit_cnt_reg == bits_per_byte - 4'h1);
  // Table read past its address bytes
  assign param_table_read_cmd = (state_reg == frr_pkg::FRR_ST_DUMMY) ||
    (state_reg == frr_pkg::FRR_ST_DATA);

  // Bit shifter; restarts at every frame
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (cs_n_s) begin
      bit_cnt_reg <= 4'h0;
    end else if (rise) begin
      shift_reg <= byte_in;
      bit_cnt_reg <= byte_done ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  // Frame decoder; single-byte commands act only when select rises
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= frr_pkg::FRR_ST_CMD;
      cmd_reg <= 8'h00;
      byte_cnt_reg <= 3'h0;
      tbl_addr_reg <= 8'h00;
      frame_bytes_reg <= 1'b0;
    end else if (cs_n_s) begin
      state_reg <= frr_pkg::FRR_ST_CMD;
      frame_bytes_reg <= 1'b0;
    end else if (byte_done) begin
      byte_cnt_reg <= 3'h0;
      case (state_reg)
        frr_pkg::FRR_ST_CMD: begin
          cmd_reg <= byte_in;
          state_reg <= (byte_in == `FRR_CMD_PTBL_READ) ? frr_pkg::FRR_ST_ADDR
                                                       : frr_pkg::FRR_ST_IGNORE;
        end
        frr_pkg::FRR_ST_ADDR: begin
          tbl_addr_reg <= byte_in;
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
          if (byte_cnt_reg == `FRR_ADDR_BYTES - 3'h1) begin
            state_reg <= frr_pkg::FRR_ST_DUMMY;
            byte_cnt_reg <= 3'h0;
          end
        end
        frr_pkg::FRR_ST_DUMMY: begin
          if (byte_cnt_reg == `FRR_DUMMY_BYTES - 3'h1) begin
            state_reg <= frr_pkg::FRR_ST_DATA;
          end
        end
        frr_pkg::FRR_ST_DATA: begin
          state_reg <= frr_pkg::FRR_ST_DATA;
        end
        frr_pkg::FRR_ST_IGNORE: begin
          frame_bytes_reg <= 1'b1;
        end
        default: begin
          state_reg <= frr_pkg::FRR_ST_CMD;
        end
      endcase
    end
  end

  // Table contents by byte address
  function automatic logic [7:0] tbl_byte(input logic [7:0] a);
    logic [7:0] v;
    v = `FRR_TBL_UNUSED;
    case (a)
      `FRR_TA_SIG0: v = `FRR_TBL_SIG0;
      `FRR_TA_SIG1: v = `FRR_TBL_SIG1;
      `FRR_TA_SIG2: v = `FRR_TBL_SIG2;
      `FRR_TA_SIG3: v = `FRR_TBL_SIG3;
      `FRR_TA_MINOR: v = `FRR_TBL_MINOR;
      `FRR_TA_MAJOR: v = `FRR_TBL_MAJOR;
      `FRR_TA_NHDR: v = `FRR_TBL_NHDR;
      `FRR_TA_HDR_ID: v = `FRR_TBL_STD_ID;
      `FRR_TA_HDR_MINOR: v = `FRR_TBL_MINOR;
      `FRR_TA_HDR_MAJOR: v = `FRR_TBL_MAJOR;
      `FRR_TA_HDR_LEN: v = `FRR_TBL_STD_LEN;
      `FRR_TA_PTR0: v = `FRR_TBL_STD_PTR;
      `FRR_TA_PTR1: v = `FRR_TBL_ZERO;
      `FRR_TA_PTR2: v = `FRR_TBL_ZERO;
      // Bytes 07h, 0Fh and everything past the header read FFh
      default: v = `FRR_TBL_UNUSED;
    endcase
    return v;
  endfunction : tbl_byte

  // Prefetch address; the 8-bit sum wraps, so a very long read starts over
  assign tbl_addr = tbl_addr_reg + prod_cnt_reg;
  assign ff.wr_valid = param_table_read_cmd && !cs_n_s;
  assign ff.wr_data = tbl_byte(tbl_addr);
  assign prod_push = ff.wr_valid && ff.wr_ready;

  // Prefetch counter, restarted with every frame
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prod_cnt_reg <= 8'h00;
    end else if (cs_n_s) begin
      prod_cnt_reg <= 8'h00;
    end else if (prod_push) begin
      prod_cnt_reg <= prod_cnt_reg + 8'h01;
    end
  end

  // Buffer hides the lookup from the shifter; flushed whenever select is high
  frr_fifo #(.WIDTH(`FRR_FIFO_WIDTH), .DEPTH(`FRR_FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .arst_n(arst_n),
    .flush(cs_n_s),
    .f(ff)
  );

  // Shifter takes a new byte at the first falling clock of each byte
  assign load = fall && (state_reg == frr_pkg::FRR_ST_DATA) && (out_cnt_reg == 4'h0);
  assign ff.rd_ready = load;
  // Prefetch runs well ahead, but an empty buffer would read as FFh
  assign next_byte = ff.rd_valid ? ff.rd_data : `FRR_TBL_UNUSED;
  assign shift_src = load ? next_byte : out_byte_reg;

  // data out on falling edges
  // Bits change on the falling clock, so they are settled at the host's rising edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sio_out <= 4'h0;
      out_byte_reg <= 8'h00;
      out_cnt_reg <= 4'h0;
    end else if (cs_n_s || state_reg != frr_pkg::FRR_ST_DATA) begin
      out_cnt_reg <= 4'h0;
    end else if (fall) begin
      out_cnt_reg <= load ? bits_per_byte - 4'h1 : out_cnt_reg - 4'h1;
      if (four_line_cmd_mode) begin
        sio_out <= shift_src[7:4];
        out_byte_reg <= {shift_src[3:0], 4'h0};
      end else begin
        sio_out <= {2'h0, shift_src[7], 1'h0};
        out_byte_reg <= {shift_src[6:0], 1'h0};
      end
    end
  end

  // drive stops with select
  // Select passes the synchroniser, so the drive lasts three core cycles past it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sio_oe <= 4'h0;
    end else if (cs_n_s || state_reg != frr_pkg::FRR_ST_DATA) begin
      sio_oe <= 4'h0;
    end else if (load) begin
      sio_oe <= four_line_cmd_mode ? `FRR_OE_QUAD : `FRR_OE_SINGLE;
    end
  end

  // One-byte commands count only when select rises on a byte boundary
  assign cmd_first = byte_done && (state_reg == frr_pkg::FRR_ST_CMD);
  assign cmd_ok = cs_rise && (state_reg == frr_pkg::FRR_ST_IGNORE) && !frame_bytes_reg
    && (bit_cnt_reg == 4'h0) && !recovering;
  assign resume_go = cmd_ok && (cmd_reg == `FRR_CMD_RESUME) && !perf_enh_mode
    && (erase_held_flag || program_held_flag);
  assign rst_go = cmd_ok && (cmd_reg == `FRR_CMD_RST_EXEC) && reset_arm_cmd;

  // other command bytes disarm
  // The execute byte itself must not disarm, or the reset could never fire
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_arm_cmd <= 1'b0;
    end else if (cmd_first && byte_in != `FRR_CMD_RST_EXEC) begin
      reset_arm_cmd <= 1'b0;
    end else if (cs_rise) begin
      reset_arm_cmd <= cmd_ok && (cmd_reg == `FRR_CMD_RST_ARM);
    end
  end

  // held flags cleared on resume
  // A new suspend in the same cycle wins over the clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      erase_held_flag <= 1'b0;
      program_held_flag <= 1'b0;
    end else begin
      if (erase_held_set) begin
        erase_held_flag <= 1'b1;
      end else if (resume_go || rst_go) begin
        erase_held_flag <= 1'b0;
      end
      if (program_held_set) begin
        program_held_flag <= 1'b1;
      end else if (resume_go || rst_go) begin
        program_held_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_flag <= 1'b0;
    end else if (resume_go) begin
      busy_flag <= 1'b1;
    end else if (write_done || rst_go) begin
      busy_flag <= 1'b0;
    end
  end

  // Event pulses for the write engine, one cycle each
  // abort only if busy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resume_pulse <= 1'b0;
      soft_reset_pulse <= 1'b0;
      write_abort_pulse <= 1'b0;
    end else begin
      resume_pulse <= resume_go;
      soft_reset_pulse <= rst_go;
      write_abort_pulse <= rst_go && busy_flag;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rec_cnt_reg <= 32'h0000_0000;
      recovering <= 1'b0;
    end else if (rst_go) begin
      rec_cnt_reg <= `FRR_RECOVERY_CYC;
      recovering <= 1'b1;
    end else if (rec_cnt_reg != 32'h0000_0000) begin
      rec_cnt_reg <= rec_cnt_reg - 32'h0000_0001;
      recovering <= (rec_cnt_reg != 32'h0000_0001);
    end
  end

  // Resume taken with no new suspend in the same cycle
  sequence seq_resume_clean;
    resume_go && !erase_held_set && !program_held_set;
  endsequence
  // Execute frame that found the arm already standing
  sequence seq_armed_exec;
    reset_arm_cmd ##1 rst_go;
  endsequence
  AST_RESUME_CLEARS: assert property (seq_resume_clean |=>
    !erase_held_flag && !program_held_flag) else $error("held flag survived resume");
  AST_BUSY_HOLDS: assert property (busy_flag && !write_done && !rst_go |=> busy_flag)
    else $error("busy dropped early");
  AST_PERF_BLOCKS: assert property (
    cmd_ok && (cmd_reg == `FRR_CMD_RESUME) && perf_enh_mode |=> !resume_pulse)
    else $error("resume taken in enhance mode");
  AST_NOP_DISARMS: assert property (cmd_first && byte_in == `FRR_CMD_NOP |=> !reset_arm_cmd)
    else $error("no-op left reset armed");
  AST_EXEC_RESETS: assert property (seq_armed_exec |=>
    soft_reset_pulse && recovering && !busy_flag && !reset_arm_cmd) else $error("reset incomplete");
  AST_OE_RELEASE: assert property (cs_n_s |=> sio_oe == 4'h0)
    else $error("data still driven after select");
endmodule : frr_cmd

// File: inc/frr_defs.svh
`ifndef FRR_DEFS_SVH
`define FRR_DEFS_SVH
// Command codes
`define FRR_CMD_RESUME 8'h30
`define FRR_CMD_NOP 8'h00
`define FRR_CMD_RST_ARM 8'h66
`define FRR_CMD_RST_EXEC 8'h99
`define FRR_CMD_PTBL_READ 8'h5A
// Parameter table contents
`define FRR_TBL_SIG0 8'h53
`define FRR_TBL_SIG1 8'h46
`define FRR_TBL_SIG2 8'h44
`define FRR_TBL_SIG3 8'h50
`define FRR_TBL_MINOR 8'h06
`define FRR_TBL_MAJOR 8'h01
`define FRR_TBL_NHDR 8'h02
`define FRR_TBL_UNUSED 8'hFF
`define FRR_TBL_STD_ID 8'h00
`define FRR_TBL_STD_LEN 8'h10
`define FRR_TBL_STD_PTR 8'h30
`define FRR_TBL_ZERO 8'h00
`define FRR_TBL_LAST 8'h0F
// Table byte addresses
`define FRR_TA_SIG0 8'h00
`define FRR_TA_SIG1 8'h01
`define FRR_TA_SIG2 8'h02
`define FRR_TA_SIG3 8'h03
`define FRR_TA_MINOR 8'h04
`define FRR_TA_MAJOR 8'h05
`define FRR_TA_NHDR 8'h06
`define FRR_TA_HDR_ID 8'h08
`define FRR_TA_HDR_MINOR 8'h09
`define FRR_TA_HDR_MAJOR 8'h0A
`define FRR_TA_HDR_LEN 8'h0B
`define FRR_TA_PTR0 8'h0C
`define FRR_TA_PTR1 8'h0D
`define FRR_TA_PTR2 8'h0E
// Output enables while shifting table data
`define FRR_OE_SINGLE 4'h2
`define FRR_OE_QUAD 4'hF
// Address and dummy byte counts of a table read
`define FRR_ADDR_BYTES 3'h3
`define FRR_DUMMY_BYTES 3'h1
// Reset recovery time in ns, then in core cycles (rounded up)
`define FRR_RECOVERY_NS 32'h0000_61A8
`define FRR_CLK_NS 32'h0000_0019
`define FRR_RECOVERY_CYC ((`FRR_RECOVERY_NS + `FRR_CLK_NS - 32'h0000_0001) / `FRR_CLK_NS)
// Bit counts per command byte
`define FRR_BITS_SINGLE 4'h8
`define FRR_BITS_QUAD 4'h2
`define FRR_FIFO_DEPTH 16
`define FRR_FIFO_WIDTH 8
`endif

// File: inc/frr_pkg.sv
package frr_pkg;
  typedef enum logic [2:0] {
    FRR_ST_CMD = 3'b000,
    FRR_ST_ADDR = 3'b001,
    FRR_ST_DUMMY = 3'b010,
    FRR_ST_DATA = 3'b011,
    FRR_ST_IGNORE = 3'b100
  } frr_state_t;
endpackage : frr_pkg

// File: inc/frr_fifo_if.sv
`timescale 1ns/1ps
interface frr_fifo_if;
  logic [7:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  modport src (output wr_data, output wr_valid, input wr_ready,
    input rd_data, input rd_valid, output rd_ready);
  modport buf_side (input wr_data, input wr_valid, output wr_ready,
    output rd_data, output rd_valid, input rd_ready);
endinterface : frr_fifo_if

// File: rtl/frr_fifo.sv
`timescale 1ns/1ps
module frr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flush,
  frr_fifo_if.buf_side f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign f.wr_ready = (count_reg != (AW+1)'(DEPTH)) && !flush;
  assign f.rd_valid = (count_reg != '0);
  assign f.rd_data = mem[rptr_reg];
  assign push = f.wr_valid && f.wr_ready;
  assign pop = f.rd_valid && f.rd_ready && !flush;

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= f.wr_data;
    end
  end

  // Pointers and fill level; flush drops everything at frame end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + AW'(1);
      end
      if (pop) begin
        rptr_reg <= rptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : frr_fifo

// File: rtl/frr_sync.sv
`timescale 1ns/1ps
module frr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // Two stages; first stage read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '1;
      q <= '1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : frr_sync

// File: tb/frr_host_model.sv
`timescale 1ns/1ps
module frr_host_model (
  input wire logic core_clk,
  input wire logic four_line,
  input wire logic [3:0] sio_out,
  input wire logic [3:0] sio_oe,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] sio_in
);
  // Half of the 200 ns link period in 25 ns core cycles
  localparam int HALF = 4;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio_in = 4'h0;
  end
  task automatic half();
    repeat (HALF) @(negedge core_clk);
  endtask : half
  task automatic start();
    @(negedge core_clk);
    cs_n = 1'b0;
    half();
  endtask : start
  // released lines show inverse, not a stale value
  task automatic stop();
    half();
    cs_n = 1'b1;
    sio_in = ~sio_in;
    half();
  endtask : stop
  // upper lines toggle in single-line mode to prove they are ignored
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < (four_line ? 2 : 8); i++) begin
      if (four_line) sio_in = tx[7-4*i -: 4];
      else sio_in = {~sio_in[3:1], tx[7-i]};
      half();
      sclk = 1'b1;
      rx = {rx[6:0], sio_oe[1] ? sio_out[1] : ~rx[0]};
      half();
      sclk = 1'b0;
    end
  endtask : xfer
  // Whole one-byte command frame
  task automatic cmd(input logic [7:0] c);
    logic [7:0] r;
    start();
    xfer(c, r);
    stop();
  endtask : cmd
endmodule : frr_host_model

// File: tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb;
  logic core_clk, arst_n, four_line, perf, e_set, p_set, wdone;
  logic cs_n, sclk, eh, ph, busy, rsm, srst, abrt, recov, arm;
  logic [3:0] sio_in, sio_out, sio_oe;
  logic [7:0] rx;
  logic [7:0] tbl [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hFF,
    8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF};
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int n_rst = 0;
  int n_abrt = 0;
  int n_rsm = 0;
  frr_cmd DUT (.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
    .sio_in(sio_in), .four_line_cmd_mode(four_line), .perf_enh_mode(perf),
    .erase_held_set(e_set), .program_held_set(p_set), .write_done(wdone),
    .sio_out(sio_out), .sio_oe(sio_oe), .erase_held_flag(eh), .program_held_flag(ph),
    .busy_flag(busy), .resume_pulse(rsm), .soft_reset_pulse(srst),
    .write_abort_pulse(abrt), .recovering(recov), .reset_arm_cmd(arm));
  frr_host_model host (.core_clk(core_clk), .four_line(four_line), .sio_out(sio_out),
    .sio_oe(sio_oe), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Pulse counters and hang guard; a hang counts as a mismatch
  always @(posedge core_clk) begin
    cyc++;
    if (srst === 1'b1) n_rst++;
    if (abrt === 1'b1) n_abrt++;
    if (rsm === 1'b1) n_rsm++;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end
  // Same-clock strobes from the write engine: 0 erase held, 1 program held, 2 done
  task automatic pulse(input int which);
    if (which == 0) e_set = 1'b1;
    else if (which == 1) p_set = 1'b1;
    else wdone = 1'b1;
    @(negedge core_clk);
    {e_set, p_set, wdone} = 3'h0;
    repeat (8) @(negedge core_clk);
  endtask : pulse
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    {four_line, perf, e_set, p_set, wdone} = 5'h00;
    arst_n = 1'b0;
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    // Table read: command, three address bytes, one dummy, sixteen data bytes
    host.start();
    for (int i = 0; i < 5; i++) host.xfer(i == 0 ? 8'h5A : 8'h00, rx);
    for (int i = 0; i < 16; i++) begin
      host.xfer(8'h00, rx);
      `CHK("tbl_byte", tbl[i], rx)
    end
    host.stop();
    `CHK("so_released", 1'b0, sio_oe[1])
    $display("test table_read done");
    // Resume of each held kind, with no write-latch command before it
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      `CHK("held_set", 2'b01 << k, {ph, eh})
      host.cmd(8'h30);
      repeat (8) @(negedge core_clk);
      `CHK("held_clr", 2'b00, {ph, eh})
      `CHK("busy_on", 1'b1, busy)
      pulse(2);
      `CHK("busy_off", 1'b0, busy)
    end
    `CHK("resume_cnt", 2, n_rsm)
    $display("test resume done");
    // Resume refused while enhance mode is on
    pulse(0);
    perf = 1'b1;
    host.cmd(8'h30);
    repeat (8) @(negedge core_clk);
    `CHK("perf_held", 1'b1, eh)
    perf = 1'b0;
    host.cmd(8'h30);
    repeat (8) @(negedge core_clk);
    `CHK("perf_off_clr", 1'b0, eh)
    `CHK("resume_cnt", 3, n_rsm)
    $display("test perf_mode done");
    // Arm, cancel by no-op, then execute must be ignored
    pulse(1);
    host.cmd(8'h66);
    `CHK("armed", 1'b1, arm)
    host.cmd(8'h00);
    `CHK("nop_disarm", 1'b0, arm)
    `CHK("nop_keeps", 1'b1, ph)
    host.cmd(8'h99);
    `CHK("no_reset", 0, n_rst)
    $display("test arm_cancel done");
    // Four-line reset during a resumed write aborts it and restores defaults
    host.cmd(8'h30);
    pulse(0);
    `CHK("resume_cnt", 4, n_rsm)
    four_line = 1'b1;
    host.cmd(8'h66);
    host.cmd(8'h99);
    repeat (8) @(negedge core_clk);
    `CHK("reset_cnt", 1, n_rst)
    `CHK("abort_cnt", 1, n_abrt)
    `CHK("defaults", 3'b000, {busy, ph, eh})
    `CHK("recov_on", 1'b1, recov)
    for (int w = 0; w < 2000 && recov !== 1'b0; w++) @(negedge core_clk);
    `CHK("recov_off", 1'b0, recov)
    four_line = 1'b0;
    $display("test soft_reset done");
    test_done();
  end
endmodule : tb
